// [hw/aofm_params.svh]
// Constants for the analog output fault manager: register offsets,
// field positions, reset values and timing counts.
// Assumes a 25 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef AOFM_PARAMS_SVH
`define AOFM_PARAMS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define AOFM_CLK_HZ 25000000
`define AOFM_COMMS_PERSIST_MS 500
`define AOFM_COMMS_PERSIST_CYC \
  (`AOFM_COMMS_PERSIST_MS * (`AOFM_CLK_HZ / 1000))

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define AOFM_REG_CTRL 12'h000
`define AOFM_REG_STATUS 12'h004
`define AOFM_REG_CH_CFG 12'h010
`define AOFM_REG_FAULT_VAL 12'h020
`define AOFM_REG_USER_VAL 12'h030
`define AOFM_REG_OUT_ECHO 12'h040
`define AOFM_CH_BLOCK_MASK 12'hFF0

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define AOFM_CTRL_OUT_EN_BIT 0
`define AOFM_CFG_FAULT_MODE_BIT 9
`define AOFM_ST_CONV_BIT 0
`define AOFM_ST_POWER_BIT 1
`define AOFM_ST_COMMS_BIT 2
`define AOFM_ST_WDT_BIT 3
`define AOFM_ST_ONLINE_BIT 4
`define AOFM_ST_PERSIST_BIT 5
`define AOFM_CTRL_RESET 32'h0000_0000
`define AOFM_CFG_RESET 32'h0000_0000

`endif

// [hw/aofm_pkg.sv]
// Types shared by the analog output fault manager.
// Assumes aofm_params.svh is available on the include path.
`default_nettype none
package aofm_pkg;

  // ****************************************************************
  // Fault inputs as one group
  // ****************************************************************
  typedef struct packed {
    logic backplane_online;
    logic converter_fault;
    logic watchdog_timeout_flag;
    logic field_power_fault;
    logic comms_fault;
  } aofm_faults_t;

  // ****************************************************************
  // Channel drive condition, highest priority first
  // ****************************************************************
  typedef enum logic [2:0] {
    AOFM_DRV_OFF_POWER = 3'h0,
    AOFM_DRV_OFF_CONV = 3'h1,
    AOFM_DRV_OFF_WDT = 3'h2,
    AOFM_DRV_OFF_COMMS = 3'h3,
    AOFM_DRV_OFFLINE = 3'h4,
    AOFM_DRV_NORMAL = 3'h5
  } aofm_drive_t;

endpackage

`default_nettype wire

// [hw/aofm_fault_manager.sv]
// Analog output fault manager: chooses each channel's converter value
// from user value, fault value and the fault inputs, with registers on
// an AHB-Lite slave port.
// Assumes a single 25 MHz clock, fault pins asynchronous to it, and a
// master that issues single word transfers with no pipelining.
//
// Overview of operation
// - Any comms disruption counts as backplane offline.
// - Hold mode offline keeps last output value.
// - Back online drives most recent user value.
// - Converter fault forces zero, latched until reset.
// - Watchdog timeout forces zero, latched until reset.
// - User mode offline drives configured fault value.
// - Field power fault switches all outputs off.
// - Power fault stays latched after condition clears.
// - Comms fault beyond 500 ms forces zero.
// - Persistent comms fault keeps outputs off.
// - Short comms loss drives hold or fault value, recovers.
// - After reset, recovered comms drives user value.
// - Priority power, converter, watchdog, comms, offline.
// - Status word reports each fault condition bit.
// - Config bit 9 selects hold or user mode.
// - Output drivers disabled after reset until enabled.
`timescale 1ns/10ps
`default_nettype none
`include "aofm_params.svh"

module aofm_fault_manager #(
  parameter int NUM_CH = 4,
  parameter int DW = 16,
  parameter int COMMS_PERSIST_CYC = `AOFM_COMMS_PERSIST_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Fault pins
  input wire aofm_pkg::aofm_faults_t fault_pins,
  // Converter side
  output logic [NUM_CH*DW-1:0] dac_value,
  output logic dac_enable
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic ch_hit(input logic [11:0] addr,
                                  input logic [11:0] base);
    logic hit;
    hit = ((addr & `AOFM_CH_BLOCK_MASK) == base) &&
          (32'(addr[3:2]) < NUM_CH) && (addr[1:0] == 2'h0);
    return hit;
  endfunction

  function automatic logic [DW-1:0] pick(input logic [NUM_CH*DW-1:0] v,
                                         input logic [1:0] ch);
    logic [DW-1:0] r;
    r = v[32'(ch)*DW +: DW];
    return r;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  aofm_pkg::aofm_faults_t sync_a;
  aofm_pkg::aofm_faults_t faults;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a <= '0;
      faults <= '0;
    end
    else
    begin
      sync_a <= fault_pins;
      faults <= sync_a;
    end
  end

  // ****************************************************************
  // Fault latches
  // ****************************************************************
  logic conv_latched;
  logic wdt_latched;
  logic power_latched;
  logic comms_persist;
  logic [31:0] comms_cnt;
  logic offline;

  // A comms break is treated like the backplane going offline, and also runs the persistence count.
  assign offline = !faults.backplane_online || faults.comms_fault;

  // Only the block reset clears these; nothing software does can.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      conv_latched <= 1'b0;
      wdt_latched <= 1'b0;
      power_latched <= 1'b0;
    end
    else
    begin
      if (faults.converter_fault)
        conv_latched <= 1'b1;
      if (faults.watchdog_timeout_flag)
        wdt_latched <= 1'b1;
      if (faults.field_power_fault)
        power_latched <= 1'b1;
    end
  end

  // Counts how long the comms fault has stood without a break.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      comms_cnt <= 32'h0000_0000;
      comms_persist <= 1'b0;
    end
    else
    begin
      if (!faults.comms_fault)
        comms_cnt <= 32'h0000_0000;
      else if (comms_cnt < 32'(COMMS_PERSIST_CYC - 1))
        comms_cnt <= comms_cnt + 32'h0000_0001;
      else
        comms_persist <= 1'b1;
    end
  end

  // ****************************************************************
  // Drive condition by priority
  // ****************************************************************
  aofm_pkg::aofm_drive_t drive;

  always_comb
  begin
    if (power_latched)
      drive = aofm_pkg::AOFM_DRV_OFF_POWER;
    else if (conv_latched)
      drive = aofm_pkg::AOFM_DRV_OFF_CONV;
    else if (wdt_latched)
      drive = aofm_pkg::AOFM_DRV_OFF_WDT;
    else if (comms_persist)
      drive = aofm_pkg::AOFM_DRV_OFF_COMMS;
    else if (offline)
      drive = aofm_pkg::AOFM_DRV_OFFLINE;
    else
      drive = aofm_pkg::AOFM_DRV_NORMAL;
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [31:0] ctrl;
  logic [NUM_CH-1:0] fault_mode;
  logic [NUM_CH*DW-1:0] fault_val;
  logic [NUM_CH*DW-1:0] user_val;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic [31:0] status;

  assign status = {26'h0, comms_persist, faults.backplane_online,
                   wdt_latched, faults.comms_fault, power_latched,
                   conv_latched};

  // Address phase: a write is remembered, a read is answered next cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready)
      begin
        wr_addr <= haddr;
      end
      if (hsel && htrans[1] && hready && !hwrite)
      begin
        if (haddr == `AOFM_REG_CTRL)
          hrdata <= ctrl;
        else if (haddr == `AOFM_REG_STATUS)
          hrdata <= status;
        else if (ch_hit(haddr, `AOFM_REG_CH_CFG))
          hrdata <= 32'(fault_mode[haddr[3:2]])
                    << `AOFM_CFG_FAULT_MODE_BIT;
        else if (ch_hit(haddr, `AOFM_REG_FAULT_VAL))
          hrdata <= 32'(pick(fault_val, haddr[3:2]));
        else if (ch_hit(haddr, `AOFM_REG_USER_VAL))
          hrdata <= 32'(pick(user_val, haddr[3:2]));
        else if (ch_hit(haddr, `AOFM_REG_OUT_ECHO))
          hrdata <= 32'(pick(dac_value, haddr[3:2]));
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  // Data phase: the write lands; unmapped writes are dropped.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= `AOFM_CTRL_RESET;
      fault_mode <= '0;
      fault_val <= '0;
      user_val <= '0;
    end
    else if (wr_pend)
    begin
      if (wr_addr == `AOFM_REG_CTRL)
      begin
        ctrl <= hwdata & 32'h0000_0001;
      end
      else if (ch_hit(wr_addr, `AOFM_REG_CH_CFG))
      begin
        fault_mode[wr_addr[3:2]] <= hwdata[`AOFM_CFG_FAULT_MODE_BIT];
      end
      else if (ch_hit(wr_addr, `AOFM_REG_FAULT_VAL))
      begin
        fault_val[32'(wr_addr[3:2])*DW +: DW] <= hwdata[DW-1:0];
      end
      else if (ch_hit(wr_addr, `AOFM_REG_USER_VAL))
      begin
        // Stored even while offline so the latest value is used later.
        user_val[32'(wr_addr[3:2])*DW +: DW] <= hwdata[DW-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // Converter outputs
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dac_enable <= 1'b0;
    end
    else
    begin
      dac_enable <= ctrl[`AOFM_CTRL_OUT_EN_BIT];
    end
  end

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic [DW-1:0] next_out;

    always_comb
    begin
      case (drive)
        aofm_pkg::AOFM_DRV_OFF_POWER,
        aofm_pkg::AOFM_DRV_OFF_CONV,
        aofm_pkg::AOFM_DRV_OFF_WDT,
        aofm_pkg::AOFM_DRV_OFF_COMMS:
        begin
          next_out = '0;
        end
        aofm_pkg::AOFM_DRV_OFFLINE:
        begin
          if (fault_mode[c])
          begin
            next_out = fault_val[c*DW +: DW];
          end
          else
          begin
            next_out = dac_value[c*DW +: DW];
          end
        end
        aofm_pkg::AOFM_DRV_NORMAL:
        begin
          next_out = user_val[c*DW +: DW];
        end
        default:
        begin
          next_out = '0;
        end
      endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        dac_value[c*DW +: DW] <= '0;
      end
      else
      begin
        dac_value[c*DW +: DW] <= next_out;
      end
    end
  end

endmodule

`default_nettype wire

// [bench/aofm_checker.sv]
// Checker for the fault manager, bound to its top-level ports.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module aofm_checker #(
  parameter int NUM_CH = 4,
  parameter int DW = 16,
  parameter int COMMS_PERSIST_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus request
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  // Pins and outputs
  input wire aofm_pkg::aofm_faults_t fault_pins,
  input wire logic [NUM_CH*DW-1:0] dac_value,
  input wire logic dac_enable
);
  logic [3:0] hcnt;
  logic [4:0] act;
  logic hard;
  logic pflag;
  int ccnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  assign hard = fault_pins.converter_fault ||
    fault_pins.watchdog_timeout_flag || fault_pins.field_power_fault;
  // Counts cycles since a latching fault pin was first seen.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hcnt <= 4'h0;
    else if (hcnt != 4'h0 && hcnt != 4'hF)
      hcnt <= hcnt + 4'h1;
    else if (hcnt == 4'h0 && hard)
      hcnt <= 4'h1;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ccnt <= 0;
    else
      ccnt <= fault_pins.comms_fault ? ccnt + 1 : 0;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      pflag <= 1'b0;
    else if (ccnt > COMMS_PERSIST_CYC + 4)
      pflag <= 1'b1;
  // Marks recent causes that may move the outputs.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      act <= 5'h1F;
    else
      act <= {act[3:0], (hsel && htrans[1] && hready) ||
        $changed(fault_pins) || fault_pins.comms_fault};
  AST_RESET_OFF:
    assert property ($past(rst) |-> !dac_enable && dac_value == '0)
    else $error("Outputs not idle after reset.");
  AST_EN_CAUSE:
    assert property ($changed(dac_enable) |-> |act)
    else $error("Enable moved with no write.");
  AST_VAL_CAUSE:
    assert property ($changed(dac_value) |-> |act)
    else $error("Output moved with no cause.");
  AST_PWR_OFF:
    assert property ($rose(fault_pins.field_power_fault) |->
      ##4 dac_value == '0)
    else $error("Power fault left output on.");
  AST_PWR_LATCH:
    assert property (fault_pins.field_power_fault [*2] |->
      ##3 (dac_value == '0) [*8])
    else $error("Power fault did not stay latched.");
  AST_CONV_ZERO:
    assert property ($rose(fault_pins.converter_fault) |->
      ##4 dac_value == '0 ##6 dac_value == '0)
    else $error("Converter fault left output on.");
  AST_WDT_ZERO:
    assert property ($rose(fault_pins.watchdog_timeout_flag) |=>
      ##3 dac_value == '0 ##1 $stable(dac_value))
    else $error("Watchdog fault left output on.");
  AST_HARD_HOLD:
    assert property (hcnt >= 4'h4 |-> dac_value == '0)
    else $error("Latched fault cleared without reset.");
  AST_PERSIST_OFF:
    assert property (pflag |-> dac_value == '0 && $stable(dac_value))
    else $error("Persistent comms fault left output on.");
  cover property (hcnt == 4'h4);
  cover property (pflag && !fault_pins.comms_fault);
  cover property ($rose(dac_enable));
endmodule
bind aofm_fault_manager aofm_checker #(
  .NUM_CH(NUM_CH),
  .DW(DW),
  .COMMS_PERSIST_CYC(COMMS_PERSIST_CYC)
) u_chk (.clk, .rst, .hsel, .htrans, .hready, .fault_pins, .dac_value,
  .dac_enable);
`default_nettype wire

// [bench/aofm_bkp_model.sv]
// Backplane processor model: online state and link health pins.
// Assumes the bench commands both; pins follow one clock later.
`timescale 1ns/10ps
`default_nettype none
module aofm_bkp_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench
  input wire logic up,
  input wire logic link,
  // Pins toward the device
  output logic online,
  output logic comms_fault
);
  // Online is reported only once out of power-up.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      online <= 1'b0;
    else
      online <= up;
  // A broken link stays flagged for as long as retries fail.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      comms_fault <= 1'b0;
    else
      comms_fault <= !link;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Bench for the fault manager: bus tasks and fault sequences.
// Assumes the backplane model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`include "aofm_params.svh"
module tb_top;
  localparam int P = 20;
  logic clk, rst, hsel, hwrite, rdy, up, link, bon, bcf;
  logic hreadyout, hresp, dac_enable;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, hard;
  logic [31:0] hwdata, hrdata, rd;
  logic [63:0] dac_value;
  int n_fail, n_tests;
  wire aofm_pkg::aofm_faults_t pins;
  assign pins = {bon, hard, bcf};
  aofm_bkp_model bkp (.clk, .rst, .up, .link, .online(bon),
    .comms_fault(bcf));
  aofm_fault_manager #(.COMMS_PERSIST_CYC(P)) dut (.clk, .rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .fault_pins(pins), .dac_value,
    .dac_enable);
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) rdy <= hreadyout;
  task automatic conclude;
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Waits for the edge where ready is sampled high.
  task automatic wt;
    int i;
    i = 0;
    @(posedge clk);
    while (rdy !== 1'b1)
    begin
      i++;
      if (i > 50)
      begin
        n_fail++;
        conclude;
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  task automatic uv(input logic [31:0] v);
    bus(1'b1, `AOFM_REG_USER_VAL, v);
    bus(1'b1, `AOFM_REG_USER_VAL + 12'h004, v);
  endtask
  // Channel 0 in hold mode, channel 1 in user mode with value 7.
  task automatic setup(input logic [31:0] v);
    bus(1'b1, `AOFM_REG_CTRL, 32'h1);
    bus(1'b1, `AOFM_REG_CH_CFG + 12'h004, 32'h200);
    bus(1'b1, `AOFM_REG_FAULT_VAL + 12'h004, 32'h7);
    uv(v);
  endtask
  task automatic out(input logic [15:0] a, input logic [15:0] b);
    cyc(6);
    @(negedge clk);
    chk({16'h0, dac_value[15:0]}, {16'h0, a});
    chk({16'h0, dac_value[31:16]}, {16'h0, b});
    @(posedge clk);
  endtask
  task automatic hold_rst;
    cyc(8);
    rst <= 1'b0;
    cyc(2);
  endtask
  task automatic pwr_cycle;
    rst <= 1'b1;
    hold_rst;
  endtask
  initial
  begin
    rst = 1'b1;
    {hsel, hwrite, hard, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    {up, link} = 2'h3;
    n_fail = 0;
    n_tests = 0;
    hold_rst;
    chk({31'h0, dac_enable}, 32'h0);
    bus(1'b0, `AOFM_REG_CTRL, 32'h0);
    chk(rd, `AOFM_CTRL_RESET);
    bus(1'b0, 12'h0FC, 32'h0);
    chk(rd, 32'h0);
    setup(32'h5);
    bus(1'b0, `AOFM_REG_CH_CFG + 12'h004, 32'h0);
    chk(rd, 32'h200);
    out(16'h5, 16'h5);
    chk({31'h0, dac_enable}, 32'h1);
    up <= 1'b0;
    out(16'h5, 16'h7);
    bus(1'b0, `AOFM_REG_OUT_ECHO + 12'h004, 32'h0);
    chk(rd, 32'h7);
    uv(32'hA);
    out(16'h5, 16'h7);
    up <= 1'b1;
    out(16'hA, 16'hA);
    link <= 1'b0;
    out(16'hA, 16'h7);
    link <= 1'b1;
    out(16'hA, 16'hA);
    for (int k = 0; k < 3; k++)
    begin
      hard[k] <= 1'b1;
      link <= 1'b0;
      cyc(4);
      hard[k] <= 1'b0;
      link <= 1'b1;
      uv(32'h3);
      out(16'h0, 16'h0);
      bus(1'b0, `AOFM_REG_STATUS, 32'h0);
      chk({31'h0, rd[k == 0 ? 1 : (k == 1 ? 3 : 0)]}, 32'h1);
      pwr_cycle;
      setup(32'h9);
      out(16'h9, 16'h9);
    end
    link <= 1'b0;
    out(16'h9, 16'h7);
    cyc(P + 6);
    link <= 1'b1;
    uv(32'h4);
    out(16'h0, 16'h0);
    bus(1'b0, `AOFM_REG_STATUS, 32'h0);
    chk({31'h0, rd[`AOFM_ST_PERSIST_BIT]}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    pwr_cycle;
    setup(32'h6);
    out(16'h6, 16'h6);
    conclude;
  end
endmodule
`default_nettype wire
